// ==== t2mc_timer.sv ====
/*
 Timer two: mode and configuration registers, count and capture/reload
 registers, clock source selection, split operation, external trigger
 handling and clock output with port remapping.
 Assumes a CPU register port on the same clock; read data is registered
 and valid one cycle after the address is presented.
*/
// Functional notes
// - Split bit set gives two 8-bit halves, clear gives one 16-bit timer
// - Low byte clock: system_clock/12, system_clock, serial overflow, INT0 edge
// - Rising trigger edges act only when enabled and not baud clocking
// - In baud use, enabled edges set external flag without capture/reload
// - 16-bit clock chosen from eight sources by three select bits
// - Low byte run bit starts and stops low byte in split mode
// - Run clear: high overflow in modes 0/1, capture event in modes 2/3
// - Clock-out enable drives overflow-derived square wave on output pin
// - Split clock-out toggles on low byte overflow, frequency halved
// - Mode code from split, mode bit1, capture bit, mode bit0; the code never reads mode bit1
// - Overflow ignore bit masks full-timer overflow interrupt, reset clear
// - Alias select maps control bits 5:4 to baud or low-byte bits
// - Three-bit capture source select chooses trigger among eight
// - Count low/high bytes at 0xCC/0xCD, read-write, reset zero
// - Capture/reload bytes at 0xCA/0xCB, loaded on capture, reload source
// - Two-bit port select routes clock and trigger pins
// - Extended mode register at 0x93 answers on page 1 only
// - Mode register at 0xC9, read-write, reset zero
`include "t2mc_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module t2mc_timer (
  input  wire logic                     clk_in,
  input  wire logic                     reset_in,
  input  wire logic [7:0]               sfr_addr_in,
  input  wire logic [3:0]               sfr_page_in,
  input  wire logic                     sfr_wr_in,
  input  wire logic [7:0]               sfr_wdata_in,
  output logic      [7:0]               sfr_rdata_out,
  input  wire t2mc_pkg::t2mc_events_type events_in,
  input  wire t2mc_pkg::t2mc_async_type  async_in,
  output logic      [3:0]               clock_out_pin_out,
  output logic      [3:0]               clock_out_pin_oe_out,
  output logic                          timer_irq_out
);
  logic [7:0] mode_r, mode_ext_r, ctrl_r, pinsel_r;
  logic [7:0] cap_l_r, cap_h_r, cnt_l_r, cnt_h_r;
  logic [3:0] div_r;
  logic       cko_r, cap_prev_r, pin_prev_r;
  t2mc_pkg::t2mc_async_type sync1_r, sync2_r;

  // Register selects; page-one registers ignore other pages
  logic pg1, wr_mode, wr_ext, wr_ctrl, wr_pin;
  logic wr_capl, wr_caph, wr_cntl, wr_cnth;
  assign pg1     = sfr_page_in == `T2MC_PAGE_ONE;
  assign wr_mode = sfr_wr_in && sfr_addr_in == `T2MC_ADDR_MODE;
  assign wr_ext  = sfr_wr_in && pg1 && sfr_addr_in == `T2MC_ADDR_MODE_EXT;
  assign wr_pin  = sfr_wr_in && pg1 && sfr_addr_in == `T2MC_ADDR_PINSEL;
  assign wr_ctrl = sfr_wr_in && sfr_addr_in == `T2MC_ADDR_CTRL;
  assign wr_capl = sfr_wr_in && sfr_addr_in == `T2MC_ADDR_CAPL;
  assign wr_caph = sfr_wr_in && sfr_addr_in == `T2MC_ADDR_CAPH;
  assign wr_cntl = sfr_wr_in && sfr_addr_in == `T2MC_ADDR_CNTL;
  assign wr_cnth = sfr_wr_in && sfr_addr_in == `T2MC_ADDR_CNTH;

  // Field aliases
  logic split, low_run, rclr_en, ck_oe, main_run, baud, alias_sel;
  logic [1:0] psel;
  logic [2:0] csel;
  assign split     = mode_r[`T2MC_M_SPLIT];
  assign low_run   = mode_r[`T2MC_M_LRUN];
  assign rclr_en   = mode_r[`T2MC_M_RCLR];
  assign ck_oe     = mode_r[`T2MC_M_CKOE];
  assign main_run  = ctrl_r[`T2MC_C_RUN];
  assign alias_sel = mode_ext_r[`T2MC_E_ALIAS];
  assign baud      = ctrl_r[`T2MC_C_B5] | ctrl_r[`T2MC_C_B4];
  assign psel      = pinsel_r[7:6];
  assign csel      = mode_ext_r[2:0];

  // Two-flop synchroniser for every pin-level input
  // edges latched only if the source runs below half the clock
  always_ff @(posedge clk_in) begin
    sync1_r <= async_in;
    sync2_r <= sync1_r;
  end

  // Divide-by-twelve prescaler, free running
  always_ff @(posedge clk_in) begin
    if (reset_in || div_r == `T2MC_DIV12_LAST) begin
      div_r <= `T2MC_DIV12_ZERO;
    end else begin
      div_r <= div_r + 4'h1;
    end
  end
  logic tick12;
  assign tick12 = div_r == `T2MC_DIV12_LAST;

  // port routing of clock and trigger pins
  logic clk_pin, trig_pin;
  assign clk_pin  = sync2_r.clock_pin[psel];
  assign trig_pin = sync2_r.external_trigger_pin[psel];
  always_ff @(posedge clk_in) begin
    pin_prev_r <= reset_in ? 1'b0 : clk_pin;
  end
  logic pin_fall;
  assign pin_fall = pin_prev_r & ~clk_pin;

  logic low_tick;
  always_comb begin
    unique case ({mode_ext_r[`T2MC_E_LCS], mode_r[`T2MC_M_LX12]})
      2'b00: low_tick = tick12;
      2'b01: low_tick = 1'b1;
      2'b10: low_tick = events_in.serial_timer_overflow;
      2'b11: low_tick = events_in.ext_int0_edge;
    endcase
  end

  // low byte overflow only counts in split mode under its run bit
  logic low_ovf;
  assign low_ovf = split & low_run & low_tick & cnt_l_r == `T2MC_FULL_BYTE;

  // full or high byte clock source
  logic full_tick;
  always_comb begin
    unique case ({mode_ext_r[`T2MC_E_CKS], mode_r[`T2MC_M_X12],
                  ctrl_r[`T2MC_C_CT]})
      3'b000: full_tick = tick12;
      3'b001: full_tick = pin_fall;
      3'b010: full_tick = 1'b1;
      3'b011: full_tick = split ? low_ovf : events_in.ext_int0_edge;
      3'b100: full_tick = events_in.serial_timer_overflow;
      3'b101: full_tick = events_in.timer0_overflow;
      3'b110: full_tick = events_in.comparator_event;
      3'b111: full_tick = events_in.keypad_event;
    endcase
  end

  logic cap_src;
  always_comb begin
    unique case (csel)
      3'b000: cap_src = trig_pin;
      3'b001: cap_src = sync2_r.serial0_receive_data;
      3'b010: cap_src = sync2_r.crystal2_pin;
      3'b011: cap_src = events_in.ext_int2_edge;
      3'b100: cap_src = sync2_r.low_speed_oscillator;
      3'b101: cap_src = sync2_r.comparator_output;
      3'b110: cap_src = events_in.keypad_event;
      3'b111: cap_src = sync2_r.two_wire_clock_line;
    endcase
  end
  always_ff @(posedge clk_in) begin
    cap_prev_r <= reset_in ? 1'b0 : cap_src;
  end

  // enabled edges; capture or reload suppressed while baud clocking
  logic trig_ev, act_ev;
  assign trig_ev = (~cap_prev_r & cap_src & mode_r[`T2MC_M_REXT]) |
                   (cap_prev_r & ~cap_src & ctrl_r[`T2MC_C_FEXT]);
  assign act_ev  = trig_ev & ~baud;

  // mode decode: capture bit picks capture vs reload, bit0 auto-zero
  logic capt_mode, zero_mode;
  assign capt_mode = ctrl_r[`T2MC_C_CRL];
  assign zero_mode = ~split & capt_mode & mode_r[`T2MC_M_MB0];

  // Overflow events of each counter layout
  logic full_ovf, high_ovf;
  assign full_ovf = ~split & main_run & full_tick &
                    {cnt_h_r, cnt_l_r} == `T2MC_FULL_WORD;
  assign high_ovf = split & main_run & full_tick &
                    cnt_h_r == `T2MC_FULL_BYTE;

  // count and capture/reload; software writes win
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cnt_l_r <= `T2MC_RESET_BYTE;
      cnt_h_r <= `T2MC_RESET_BYTE;
      cap_l_r <= `T2MC_RESET_BYTE;
      cap_h_r <= `T2MC_RESET_BYTE;
    end else begin
      if (~split && main_run && full_tick) begin
        if (full_ovf && !capt_mode) begin
          {cnt_h_r, cnt_l_r} <= {cap_h_r, cap_l_r};
        end else begin
          {cnt_h_r, cnt_l_r} <= {cnt_h_r, cnt_l_r} + 16'h0001;
        end
      end
      if (split && low_run && low_tick) begin
        cnt_l_r <= low_ovf ? cap_l_r : cnt_l_r + 8'h01;
      end
      if (split && main_run && full_tick) begin
        cnt_h_r <= high_ovf ? cap_h_r : cnt_h_r + 8'h01;
      end
      if (act_ev && capt_mode) begin
        cap_l_r <= cnt_l_r;
        cap_h_r <= cnt_h_r;
        if (zero_mode) begin
          {cnt_h_r, cnt_l_r} <= {`T2MC_RESET_BYTE, `T2MC_RESET_BYTE};
        end
      end else if (act_ev && ~split) begin
        {cnt_h_r, cnt_l_r} <= {cap_h_r, cap_l_r};
      end
      if (wr_cntl) cnt_l_r <= sfr_wdata_in;
      if (wr_cnth) cnt_h_r <= sfr_wdata_in;
      if (wr_capl) cap_l_r <= sfr_wdata_in;
      if (wr_caph) cap_h_r <= sfr_wdata_in;
    end
  end

  // hardware clear of the low run bit
  logic run_clr;
  // Split modes 2/3 are the capture codes, so the capture bit picks
  assign run_clr = rclr_en & split & (capt_mode ? act_ev : high_ovf);

  // mode register, clear wins only over software set of run
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      mode_r <= `T2MC_RESET_BYTE;
    end else begin
      if (wr_mode) mode_r <= sfr_wdata_in;
      if (run_clr) mode_r[`T2MC_M_LRUN] <= 1'b0;
    end
  end

  // Extended mode and pin select registers
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      mode_ext_r <= `T2MC_RESET_BYTE;
      pinsel_r   <= `T2MC_RESET_BYTE;
    end else begin
      if (wr_ext) mode_ext_r <= sfr_wdata_in;
      if (wr_pin) pinsel_r <= {sfr_wdata_in[7:6], 6'h00};
    end
  end

  // Flags: hardware set wins over a software clear in the same cycle
  logic set_tf2, set_low_byte_overflow_flag, set_external_flag;
  logic low_byte_overflow_flag_r, tl_ie_r;
  assign set_tf2  = (full_ovf & ~baud) | high_ovf;
  assign set_low_byte_overflow_flag = low_ovf;
  // external flag set on every enabled edge, baud use included
  assign set_external_flag = trig_ev;
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ctrl_r  <= `T2MC_RESET_BYTE;
      low_byte_overflow_flag_r  <= 1'b0;
      tl_ie_r <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_r[`T2MC_C_FEXT:0] <= sfr_wdata_in[`T2MC_C_FEXT:0];
        ctrl_r[`T2MC_C_TF2]  <= sfr_wdata_in[`T2MC_C_TF2] | set_tf2;
        ctrl_r[`T2MC_C_EXTERNAL_FLAG] <= sfr_wdata_in[`T2MC_C_EXTERNAL_FLAG] | set_external_flag;
      end else begin
        ctrl_r[`T2MC_C_TF2]  <= ctrl_r[`T2MC_C_TF2] | set_tf2;
        ctrl_r[`T2MC_C_EXTERNAL_FLAG] <= ctrl_r[`T2MC_C_EXTERNAL_FLAG] | set_external_flag;
      end
      // bits 5:4 reach baud selects or low-byte flag and enable
      if (wr_ctrl && !alias_sel) begin
        ctrl_r[`T2MC_C_B5] <= sfr_wdata_in[`T2MC_C_B5];
        ctrl_r[`T2MC_C_B4] <= sfr_wdata_in[`T2MC_C_B4];
      end
      if (wr_ctrl && alias_sel) begin
        low_byte_overflow_flag_r  <= sfr_wdata_in[`T2MC_C_B5] | set_low_byte_overflow_flag;
        tl_ie_r <= sfr_wdata_in[`T2MC_C_B4];
      end else begin
        low_byte_overflow_flag_r  <= low_byte_overflow_flag_r | set_low_byte_overflow_flag;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      timer_irq_out <= 1'b0;
    end else begin
      timer_irq_out <= (ctrl_r[`T2MC_C_TF2] & ~mode_ext_r[`T2MC_E_IGN]) |
                       ctrl_r[`T2MC_C_EXTERNAL_FLAG] | (low_byte_overflow_flag_r & tl_ie_r);
    end
  end

  // clock out toggles on overflow, halving the overflow rate
  always_ff @(posedge clk_in) begin
    if (reset_in || !ck_oe) begin
      cko_r <= 1'b0;
    end else if (split ? low_ovf : full_ovf) begin
      cko_r <= ~cko_r;
    end
  end
  // value copied to all four pins; enable only on the selected pin while driving
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      clock_out_pin_out    <= 4'h0;
      clock_out_pin_oe_out <= 4'h0;
    end else begin
      clock_out_pin_out    <= {4{cko_r}};
      clock_out_pin_oe_out <= (ck_oe ? 4'h1 : 4'h0) << psel;
    end
  end

  // Registered read; unmapped addresses read zero
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      sfr_rdata_out <= `T2MC_RESET_BYTE;
    end else begin
      unique case (sfr_addr_in)
        `T2MC_ADDR_CTRL: sfr_rdata_out <= alias_sel ?
          {ctrl_r[7:6], low_byte_overflow_flag_r, tl_ie_r, ctrl_r[3:0]} : ctrl_r;
        `T2MC_ADDR_MODE: sfr_rdata_out <= mode_r;
        `T2MC_ADDR_CAPL: sfr_rdata_out <= cap_l_r;
        `T2MC_ADDR_CAPH: sfr_rdata_out <= cap_h_r;
        `T2MC_ADDR_CNTL: sfr_rdata_out <= cnt_l_r;
        `T2MC_ADDR_CNTH: sfr_rdata_out <= cnt_h_r;
        `T2MC_ADDR_MODE_EXT:
          sfr_rdata_out <= pg1 ? mode_ext_r : `T2MC_RESET_BYTE;
        `T2MC_ADDR_PINSEL:
          sfr_rdata_out <= pg1 ? pinsel_r : `T2MC_RESET_BYTE;
        default: sfr_rdata_out <= `T2MC_RESET_BYTE;
      endcase
    end
  end

  property p_low_wrap;
    @(posedge clk_in) disable iff (reset_in)
    low_ovf && !wr_cntl |=> cnt_l_r == $past(cap_l_r);
  endproperty
  a_low_wrap: assert property (p_low_wrap)
    else $error("Low byte did not reload on overflow");

  property p_low_hold;
    @(posedge clk_in) disable iff (reset_in)
    split && !low_run && !wr_cntl && !act_ev |=> $stable(cnt_l_r);
  endproperty
  a_low_hold: assert property (p_low_hold)
    else $error("Stopped low byte changed");

  property p_no_edge;
    @(posedge clk_in) disable iff (reset_in)
    !mode_r[`T2MC_M_REXT] && !ctrl_r[`T2MC_C_FEXT] && !wr_ctrl
      && !ctrl_r[`T2MC_C_EXTERNAL_FLAG] |=> !ctrl_r[`T2MC_C_EXTERNAL_FLAG];
  endproperty
  a_no_edge: assert property (p_no_edge)
    else $error("External flag set with edges disabled");

  property p_baud_edge;
    @(posedge clk_in) disable iff (reset_in)
    baud && trig_ev && !wr_capl |=> ctrl_r[`T2MC_C_EXTERNAL_FLAG]
      && $stable(cap_l_r);
  endproperty
  a_baud_edge: assert property (p_baud_edge)
    else $error("Baud edge mishandled");

  property p_run_clr;
    @(posedge clk_in) disable iff (reset_in)
    rclr_en && split && !capt_mode && high_ovf |=> !low_run;
  endproperty
  a_run_clr: assert property (p_run_clr)
    else $error("Low run not cleared by high overflow");

  property p_no_clkout;
    @(posedge clk_in) disable iff (reset_in)
    !ck_oe ##1 !ck_oe |=> clock_out_pin_oe_out == 4'h0
      && clock_out_pin_out == 4'h0;
  endproperty
  a_no_clkout: assert property (p_no_clkout)
    else $error("Clock output active while disabled");

  property p_split_toggle;
    @(posedge clk_in) disable iff (reset_in)
    ck_oe && split && low_ovf && !wr_mode |=> cko_r != $past(cko_r);
  endproperty
  a_split_toggle: assert property (p_split_toggle)
    else $error("Clock out missed low byte overflow");

  property p_ignore;
    @(posedge clk_in) disable iff (reset_in)
    ctrl_r[`T2MC_C_TF2] && !mode_ext_r[`T2MC_E_IGN] |=> timer_irq_out;
  endproperty
  a_ignore: assert property (p_ignore)
    else $error("Overflow interrupt not raised");

  property p_page;
    @(posedge clk_in) disable iff (reset_in)
    sfr_wr_in && !pg1 && sfr_addr_in == `T2MC_ADDR_MODE_EXT
      |=> $stable(mode_ext_r);
  endproperty
  a_page: assert property (p_page)
    else $error("Extended mode written off page one");

  property p_reset;
    @(posedge clk_in) reset_in |=> mode_r == `T2MC_RESET_BYTE;
  endproperty
  a_reset: assert property (p_reset)
    else $error("Mode register not zero after reset");
endmodule : t2mc_timer
`default_nettype wire

// ==== t2mc_consts.svh ====
/*
 Constants for the timer two mode and configuration block: register
 addresses, field positions, reset values and the prescale count.
 Assumes an 8-bit special function register space with 4-bit pages.
*/
`ifndef T2MC_CONSTS_SVH
`define T2MC_CONSTS_SVH
`define T2MC_ADDR_CTRL     8'hc8
`define T2MC_ADDR_MODE     8'hc9
`define T2MC_ADDR_CAPL     8'hca
`define T2MC_ADDR_CAPH     8'hcb
`define T2MC_ADDR_CNTL     8'hcc
`define T2MC_ADDR_CNTH     8'hcd
`define T2MC_ADDR_MODE_EXT 8'h93
`define T2MC_ADDR_PINSEL   8'ha4
`define T2MC_PAGE_ONE      4'h1
`define T2MC_RESET_BYTE    8'h00
`define T2MC_FULL_BYTE     8'hff
`define T2MC_FULL_WORD     16'hffff
`define T2MC_DIV12_LAST    4'hb
`define T2MC_DIV12_ZERO    4'h0
// Mode register fields
`define T2MC_M_SPLIT  7
`define T2MC_M_LX12   6
`define T2MC_M_REXT   5
`define T2MC_M_X12    4
`define T2MC_M_LRUN   3
`define T2MC_M_RCLR   2
`define T2MC_M_CKOE   1
`define T2MC_M_MB0    0
// Extended mode register fields
`define T2MC_E_LCS    7
`define T2MC_E_IGN    6
`define T2MC_E_ALIAS  5
`define T2MC_E_CKS    4
`define T2MC_E_MB1    3
// Control register fields
`define T2MC_C_TF2    7
`define T2MC_C_EXTERNAL_FLAG   6
`define T2MC_C_B5     5
`define T2MC_C_B4     4
`define T2MC_C_FEXT   3
`define T2MC_C_RUN    2
`define T2MC_C_CT     1
`define T2MC_C_CRL    0
`endif

// ==== t2mc_pkg.sv ====
/*
 Types for the timer two mode and configuration block.
 Assumes the constants header is included by the design file.
*/
package t2mc_pkg;
  // Same-clock event pulses from neighbouring blocks
  typedef struct packed {
    logic serial_timer_overflow;
    logic ext_int0_edge;
    logic timer0_overflow;
    logic comparator_event;
    logic keypad_event;
    logic ext_int2_edge;
  } t2mc_events_type;
  // Asynchronous pin-level inputs, synchronised before use
  typedef struct packed {
    logic [3:0] clock_pin;
    logic [3:0] external_trigger_pin;
    logic       serial0_receive_data;
    logic       crystal2_pin;
    logic       low_speed_oscillator;
    logic       comparator_output;
    logic       two_wire_clock_line;
  } t2mc_async_type;
endpackage : t2mc_pkg

// ==== t2mc_cpu.sv ====
/*
 CPU-side model of the special function register port of timer two.
 Assumes the registered read data of the timer block: data for an
 address shown before a rising edge is settled at the next falling edge.
*/
`timescale 1ns/1ns
`default_nettype none
module t2mc_cpu (
  input  wire logic       clk_in,
  input  wire logic [7:0] sfr_rdata_in,
  output logic      [7:0] sfr_addr_out,
  output logic      [3:0] sfr_page_out,
  output logic            sfr_wr_out,
  output logic      [7:0] sfr_wdata_out
);
  // Idle bus at time zero
  initial begin
    sfr_addr_out  = 8'h00;
    sfr_page_out  = 4'h0;
    sfr_wr_out    = 1'b0;
    sfr_wdata_out = 8'h00;
  end

  // One write: strobe held across exactly one rising edge
  task automatic wr(input logic [7:0] a, input logic [3:0] p,
                    input logic [7:0] d);
    @(negedge clk_in);
    sfr_addr_out  = a;
    sfr_page_out  = p;
    sfr_wr_out    = 1'b1;
    sfr_wdata_out = d;
    @(negedge clk_in);
    sfr_wr_out    = 1'b0;
    sfr_wdata_out = ~d; // Released data must not look like a valid write
  endtask : wr

  // One read: address held until the registered answer has settled
  task automatic rd(input logic [7:0] a, input logic [3:0] p,
                    output logic [7:0] d);
    @(negedge clk_in);
    sfr_addr_out = a;
    sfr_page_out = p;
    @(negedge clk_in);
    d = sfr_rdata_in;
  endtask : rd
endmodule : t2mc_cpu
`default_nettype wire

// ==== t2mc_timer_test.sv ====
/*
 Self-checking bench for the timer two mode and configuration block.
 Assumes the CPU model in t2mc_cpu.sv; inputs change at falling edges.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin \
  total_checks++; \
  if ((g) !== (e)) begin \
    error_cnt++; \
    $display("Error %s expected %h seen %h", nm, e, g); \
  end \
end
module t2mc_timer_test;
  logic                      clk_in;
  logic                      reset_in;
  logic [7:0]                sfr_addr;
  logic [3:0]                sfr_page;
  logic                      sfr_wr;
  logic [7:0]                sfr_wdata;
  logic [7:0]                sfr_rdata;
  t2mc_pkg::t2mc_events_type events;
  t2mc_pkg::t2mc_async_type  async_pins;
  logic [3:0]                cko;
  logic [3:0]                cko_oe;
  logic                      irq;
  int                        error_cnt;
  int                        total_checks;

  t2mc_timer t2mc_timer_i (
    .clk_in(clk_in), .reset_in(reset_in), .sfr_addr_in(sfr_addr),
    .sfr_page_in(sfr_page), .sfr_wr_in(sfr_wr), .sfr_wdata_in(sfr_wdata),
    .sfr_rdata_out(sfr_rdata), .events_in(events), .async_in(async_pins),
    .clock_out_pin_out(cko), .clock_out_pin_oe_out(cko_oe),
    .timer_irq_out(irq));

  t2mc_cpu t2mc_cpu_i (
    .clk_in(clk_in), .sfr_rdata_in(sfr_rdata), .sfr_addr_out(sfr_addr),
    .sfr_page_out(sfr_page), .sfr_wr_out(sfr_wr),
    .sfr_wdata_out(sfr_wdata));

  // 100 MHz clock
  always #5 clk_in = ~clk_in;

  task automatic w(input logic [7:0] a, input logic [7:0] d,
                   input logic [3:0] p = 4'h0);
    t2mc_cpu_i.wr(a, p, d);
  endtask : w

  // Read one register and compare it with the expected byte
  task automatic rc(input string nm, input logic [7:0] a,
                    input logic [7:0] e, input logic [3:0] p = 4'h0);
    logic [7:0] d;
    t2mc_cpu_i.rd(a, p, d);
    `CHK(nm, e, d)
  endtask : rc

  // reset values of all page-free registers
  task automatic t_reset();
    for (int i = 0; i < 6; i++) begin
      rc("reset", 8'hc8 + 8'(i), 8'h00);
    end
    rc("mode ext reset", 8'h93, 8'h00, 4'h1);
    $display("test reset done");
  endtask : t_reset

  // read-write access; low run bit set but split off, so no count
  task automatic t_rw();
    for (int i = 1; i < 6; i++) begin
      w(8'hc8 + 8'(i), 8'h5a + 8'(i));
    end
    repeat (10) @(negedge clk_in);
    for (int i = 1; i < 6; i++) begin
      rc("rw", 8'hc8 + 8'(i), 8'h5a + 8'(i));
    end
    for (int i = 1; i < 6; i++) begin
      w(8'hc8 + 8'(i), 8'h00);
    end
    w(8'h93, 8'h55);
    rc("ext off page", 8'h93, 8'h00, 4'h1);
    w(8'h93, 8'h55, 4'h1);
    rc("ext page one", 8'h93, 8'h55, 4'h1);
    rc("ext page zero", 8'h93, 8'h00);
    rc("unmapped", 8'h80, 8'h00);
    w(8'h93, 8'h00, 4'h1);
    $display("test rw done");
  endtask : t_rw

  // control bits 5:4 switch between baud and low-byte meanings
  task automatic t_alias();
    w(8'hc8, 8'h30);
    rc("baud sel", 8'hc8, 8'h30);
    w(8'h93, 8'h20, 4'h1);
    rc("alias view", 8'hc8, 8'h00);
    w(8'hc8, 8'h10);
    rc("low ie", 8'hc8, 8'h10);
    // Low-byte enable off again so later interrupts are not polluted
    w(8'hc8, 8'h00);
    w(8'h93, 8'h00, 4'h1);
    rc("baud back", 8'hc8, 8'h30);
    w(8'hc8, 8'h00);
    $display("test alias done");
  endtask : t_alias

  // overflow interrupt and its ignore bit; reload from capture regs
  task automatic t_ovf();
    int n;
    w(8'hcb, 8'h12);
    w(8'hca, 8'h34);
    w(8'hcd, 8'hff);
    w(8'hcc, 8'hff);
    w(8'hc9, 8'h10);
    w(8'hc8, 8'h04);
    n = 0;
    while (irq !== 1'b1 && n < 20) begin
      @(negedge clk_in);
      n++;
    end
    `CHK("ovf irq", 1'b1, irq)
    rc("ovf flag", 8'hc8, 8'h84);
    w(8'hc8, 8'h00);
    rc("reload high", 8'hcd, 8'h12);
    w(8'h93, 8'h40, 4'h1);
    w(8'hcd, 8'hff);
    w(8'hcc, 8'hff);
    w(8'hc8, 8'h04);
    repeat (20) @(negedge clk_in);
    `CHK("masked irq", 1'b0, irq)
    rc("masked flag", 8'hc8, 8'h84);
    w(8'hc8, 8'h00);
    w(8'h93, 8'h00, 4'h1);
    $display("test overflow done");
  endtask : t_ovf

  // trigger edges; pins change slowly, well under half the clock
  task automatic t_trig();
    w(8'hcd, 8'h56);
    w(8'hcc, 8'h78);
    w(8'hc8, 8'h01);
    w(8'hc9, 8'h20);
    async_pins.external_trigger_pin[0] = 1'b1;
    repeat (8) @(negedge clk_in);
    rc("cap low", 8'hca, 8'h78);
    rc("cap high", 8'hcb, 8'h56);
    rc("ext flag", 8'hc8, 8'h41);
    `CHK("ext irq", 1'b1, irq)
    w(8'hc8, 8'h01);
    w(8'hc9, 8'h00);
    async_pins.external_trigger_pin[0] = 1'b0;
    repeat (8) @(negedge clk_in);
    w(8'hcd, 8'h11);
    async_pins.external_trigger_pin[0] = 1'b1;
    repeat (8) @(negedge clk_in);
    rc("no cap", 8'hcb, 8'h56);
    rc("no flag", 8'hc8, 8'h01);
    async_pins.external_trigger_pin[0] = 1'b0;
    repeat (8) @(negedge clk_in);
    w(8'ha4, 8'h40, 4'h1);
    w(8'hc9, 8'h22);
    w(8'hc8, 8'h11);
    async_pins.external_trigger_pin[1] = 1'b1;
    repeat (8) @(negedge clk_in);
    rc("baud no cap", 8'hcb, 8'h56);
    rc("baud flag", 8'hc8, 8'h51);
    `CHK("oe pin one", 4'b0010, cko_oe)
    w(8'hc9, 8'h20);
    repeat (2) @(negedge clk_in);
    `CHK("oe off", 4'b0000, cko_oe)
    w(8'hc8, 8'h00);
    w(8'ha4, 8'h00, 4'h1);
    w(8'hc9, 8'h00);
    async_pins.external_trigger_pin[1] = 1'b0;
    $display("test trigger done");
  endtask : t_trig

  // low byte run in split mode; hardware clear of the run bit
  task automatic t_split();
    logic [7:0] a;
    logic [7:0] b;
    w(8'hcc, 8'h00);
    w(8'hc9, 8'hc8);
    repeat (10) @(negedge clk_in);
    // Eleven system clocks pass between the run write and the read
    rc("low runs", 8'hcc, 8'h0b);
    w(8'hc9, 8'hc0);
    t2mc_cpu_i.rd(8'hcc, 4'h0, a);
    repeat (5) @(negedge clk_in);
    t2mc_cpu_i.rd(8'hcc, 4'h0, b);
    `CHK("low stops", a, b)
    w(8'hcd, 8'hff);
    w(8'hc9, 8'hdc);
    w(8'hc8, 8'h04);
    repeat (6) @(negedge clk_in);
    rc("run cleared", 8'hc9, 8'hd4);
    // split mode 2: capture edge clears run
    w(8'hc8, 8'h01);
    w(8'hc9, 8'hac);
    async_pins.external_trigger_pin[0] = 1'b1;
    repeat (8) @(negedge clk_in);
    rc("capture clear", 8'hc9, 8'ha4);
    async_pins.external_trigger_pin[0] = 1'b0;
    w(8'hc8, 8'h00);
    w(8'hc9, 8'h00);
    $display("test split done");
  endtask : t_split

  // One same-clock INT0 edge pulse, then an idle cycle
  task automatic pulse();
    events.ext_int0_edge = 1'b1;
    @(negedge clk_in);
    events.ext_int0_edge = 1'b0;
    @(negedge clk_in);
  endtask : pulse

  // low byte on INT0 edges; clock out at half the wrap rate
  task automatic t_event();
    w(8'hca, 8'hfe);
    w(8'hcc, 8'hfe);
    w(8'h93, 8'h80, 4'h1);
    w(8'hc9, 8'hca);
    repeat (2) pulse();
    `CHK("cko high", 4'hf, cko)
    `CHK("cko pin zero", 4'h1, cko_oe)
    rc("low reload", 8'hcc, 8'hfe);
    repeat (2) pulse();
    `CHK("cko low", 4'h0, cko)
    `CHK("low irq off", 1'b0, irq)
    w(8'h93, 8'ha0, 4'h1);
    rc("low flag", 8'hc8, 8'h20);
    w(8'hc8, 8'h30);
    repeat (2) @(negedge clk_in);
    `CHK("low irq on", 1'b1, irq)
    w(8'hc8, 8'h00);
    w(8'h93, 8'h00, 4'h1);
    w(8'hc9, 8'h00);
    $display("test event done");
  endtask : t_event

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  // Main sequence
  initial begin
    clk_in       = 1'b0;
    reset_in     = 1'b1;
    events       = '0;
    async_pins   = '0;
    error_cnt    = 0;
    total_checks = 0;
    repeat (4) @(negedge clk_in);
    reset_in = 1'b0;
    t_reset();
    t_rw();
    t_alias();
    t_ovf();
    t_trig();
    t_split();
    t_event();
    end_of_test();
  end

  // Watchdog: whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_in);
    error_cnt++;
    end_of_test();
  end
endmodule : t2mc_timer_test
`default_nettype wire
